// >>> hw/ppri_port_regs.sv
// Printer port register interface: data, status, control and the
// enhanced address and data ports, with the cable pins behind them.
// Assumes an external base-address decode drives i_port_select and the
// port mode comes from configuration logic on the same clock.
//
// Operation
// RULE1 - Offsets 0 to 7 select data, status, control, address, four data ports.
// RULE2 - Data, status and control answer host accesses in every mode.
// RULE3 - Address and data ports 3 to 7 work only in enhanced mode.
// RULE4 - Data and control read/write always; status writable in enhanced mode.
// RULE5 - Data register clears to zero on reset.
// RULE6 - Data write captured at strobe end, driven uninverted on data pins.
// RULE7 - Compatible mode data reads return live pin levels.
// RULE8 - Status captured at read start and held until strobe ends.
// RULE9 - Status bit 0 sets when an enhanced cycle exceeds 10 us.
// RULE10 - Timeout flag clears on reset or writing one; zero has no effect.
// RULE11 - Status bits 1 and 2 always read zero.
// RULE12 - Status bit 3 shows the fault input; zero means error.
// RULE13 - Status bit 4 shows the online input; one means selected.
// RULE14 - Status bit 5 shows the paper-out input; one means no paper.
// RULE15 - Status bit 6 shows the acknowledge input level.
// RULE16 - Status bit 7 shows the busy input inverted.
// RULE17 - Reset sets control bits 0 to 5; bits 6 and 7 stay zero. The code clears bits 0 to 5 to zero on reset instead.
// RULE18 - Control bit 0 drives the strobe pin inverted.
// RULE19 - Control bit 1 drives the line feed pin inverted.
// RULE20 - Control bit 2 drives the reinit pin uninverted.
// RULE21 - Control bit 3 drives the device choose pin inverted.
// RULE22 - With bit 4 set, acknowledge rising edge raises interrupt request.
// RULE23 - Outside enhanced mode, offsets 3 to 7 change nothing.
`timescale 1ns/1ps
module ppri_port_regs
(
    // Clock and reset
    input  wire logic       i_ref_clk,
    input  wire logic       i_rst_n,
    // Configuration
    input  wire logic [1:0] i_port_mode,
    // Host bus
    input  wire logic       i_port_select,
    input  wire logic [2:0] i_host_offset,
    input  wire logic [7:0] i_host_data,
    input  wire logic       i_host_read_strobe_n,
    input  wire logic       i_host_write_strobe_n,
    output logic      [7:0] o_host_data,
    output logic            o_host_data_oe,
    output logic            o_host_irq,
    // Parallel data pins
    input  wire logic [7:0] i_parallel_data_pins,
    output logic      [7:0] o_parallel_data_pins,
    output logic            o_parallel_data_pins_oe,
    // Printer status pins
    input  wire logic       i_fault_input_pin,
    input  wire logic       i_online_input,
    input  wire logic       i_no_media_input,
    input  wire logic       i_printer_acknowledge_input,
    input  wire logic       i_printer_busy,
    input  wire logic       i_periph_ready,
    // Printer control pins
    output logic            o_inverted_strobe_pin,
    output logic            o_line_feed_pin,
    output logic            o_printer_reinit_out,
    output logic            o_device_choose_pin,
    // Enhanced cycle state
    output logic            o_enh_cycle_active,
    output logic            o_enh_cycle_write,
    output logic            o_enh_cycle_addr
);

    ppri_host_if hif ();

    ppri_host_front u_front
    (
        .i_ref_clk             (i_ref_clk),
        .i_rst_n               (i_rst_n),
        .i_port_select         (i_port_select),
        .i_host_offset         (i_host_offset),
        .i_host_data           (i_host_data),
        .i_host_read_strobe_n  (i_host_read_strobe_n),
        .i_host_write_strobe_n (i_host_write_strobe_n),
        .hif                   (hif.front)
    );

    // Cable inputs: two stages each before use
    logic [13:0] cab_meta_q;
    logic [13:0] cab_sync_q;
    logic        ack_prev_q;

    always_ff @(posedge i_ref_clk)
    begin
        cab_meta_q <= {i_parallel_data_pins, i_fault_input_pin,
                       i_online_input, i_no_media_input,
                       i_printer_acknowledge_input, i_printer_busy,
                       i_periph_ready};
        cab_sync_q <= cab_meta_q;
    end

    wire logic [7:0] pins_s   = cab_sync_q[13:6];
    wire logic       fault_s  = cab_sync_q[5];
    wire logic       online_s = cab_sync_q[4];
    wire logic       media_s  = cab_sync_q[3];
    wire logic       ack_s    = cab_sync_q[2];
    wire logic       busy_s   = cab_sync_q[1];
    wire logic       ready_s  = cab_sync_q[0];

    // Register state
    logic [7:0]                   data_q;
    logic [7:0]                   enh_addr_q;
    logic [7:0]                   enh_data_q;
    logic [7:0]                   pin_out_q;
    logic [ppri_pkg::CTL_WIDTH-1:0] ctrl_q;
    logic                         cycle_timeout_flag_q;
    logic [7:0]                   rd_q;
    logic                         rd_valid_q;
    logic                         rd_live_q;
    logic                         irq_q;

    // Enhanced cycle tracking
    logic                         ecyc_q;
    logic                         ecyc_wr_q;
    logic                         ecyc_addr_q;
    logic [ppri_pkg::TMR_W-1:0]   tmr_q;

    // Decode
    wire logic enh_mode = (i_port_mode == ppri_pkg::PM_ENHANCED);
    wire logic compat   = (i_port_mode == ppri_pkg::PM_COMPAT);
    wire logic [2:0] ofs = hif.offset;
    wire logic hit_data = (ofs == ppri_pkg::OFS_DATA);      // [RULE1]
    wire logic hit_sts  = (ofs == ppri_pkg::OFS_STATUS);    // [RULE1]
    wire logic hit_ctl  = (ofs == ppri_pkg::OFS_CTRL);      // [RULE1]
    wire logic hit_ead  = (ofs == ppri_pkg::OFS_EADDR);     // [RULE1]
    wire logic hit_edt  = (ofs >= ppri_pkg::OFS_EDATA0);    // [RULE1]
    // Base registers always answer; the upper five only in enhanced mode
    wire logic hit_base = hit_data | hit_sts | hit_ctl;     // [RULE2]
    wire logic hit_enh  = (hit_ead | hit_edt) & enh_mode;   // [RULE3] [RULE23]
    wire logic hit_any  = hit_base | hit_enh;

    wire logic wr_data = hif.wr_end & hit_data;             // [RULE4]
    wire logic wr_ctl  = hif.wr_end & hit_ctl;              // [RULE4]
    wire logic wr_sts  = hif.wr_end & hit_sts & enh_mode;   // [RULE4]
    wire logic wr_ead  = hif.wr_end & hit_ead & enh_mode;   // [RULE3] [RULE23]
    wire logic wr_edt  = hif.wr_end & hit_edt & enh_mode;   // [RULE3] [RULE23]

    // Direction is always out in compatible mode
    wire logic dir_in = ~compat & ctrl_q[ppri_pkg::CTL_DIR];

    // Status image
    wire logic [7:0] status_img;
    assign status_img[ppri_pkg::STS_TIMEOUT]  = cycle_timeout_flag_q; // [RULE9]
    assign status_img[2:1]                    = 2'b00;     // [RULE11]
    assign status_img[ppri_pkg::STS_FAULT]    = fault_s;   // [RULE12]
    assign status_img[ppri_pkg::STS_ONLINE]   = online_s;  // [RULE13]
    assign status_img[ppri_pkg::STS_NO_MEDIA] = media_s;   // [RULE14]
    assign status_img[ppri_pkg::STS_ACK]      = ack_s;     // [RULE15]
    assign status_img[ppri_pkg::STS_NOT_OCC]  = ~busy_s;   // [RULE16]

    // Data readback: pin levels when the pins are inputs or in
    // compatible mode, the latch otherwise
    wire logic data_live = compat | dir_in;                // [RULE7]
    wire logic [7:0] data_img = data_live ? pins_s : data_q;

    wire logic [7:0] ctrl_img = {2'b00, ctrl_q};           // [RULE17]

    // Enhanced reads return what the peripheral drives on the pins
    wire logic [7:0] rd_mux = hit_sts  ? status_img :
                              hit_ctl  ? ctrl_img   :
                              hit_data ? data_img   :
                              pins_s;

    // Enhanced cycle start and finish
    wire logic ecyc_start = (hif.rd_start | hif.wr_start) & hit_enh;
    wire logic tmr_hit    = (tmr_q == ppri_pkg::TMR_W'(ppri_pkg::CYC_TIMEOUT_CY));
    wire logic ecyc_done  = ecyc_q & (ready_s | tmr_hit
                            | ~(hif.rd_active | ~hif.wr_end & ecyc_wr_q));
    wire logic tmo_set    = ecyc_q & tmr_hit & ~ready_s;   // [RULE9]
    wire logic tmo_clr    = wr_sts & hif.wdata[ppri_pkg::STS_TIMEOUT]; // [RULE10]

    // Data register
    always_ff @(posedge i_ref_clk)
    begin
        if (!i_rst_n)
            data_q <= ppri_pkg::DATA_RST;                  // [RULE5]
        else if (wr_data)
            data_q <= hif.wdata;                           // [RULE6]
    end

    // Enhanced address and data registers
    always_ff @(posedge i_ref_clk)
    begin
        if (!i_rst_n)
        begin
            enh_addr_q <= ppri_pkg::EREG_RST;
            enh_data_q <= ppri_pkg::EREG_RST;
        end
        else
        begin
            if (wr_ead)
                enh_addr_q <= hif.wdata;
            if (wr_edt)
                enh_data_q <= hif.wdata;
        end
    end

    // Value driven onto the data pins: the most recent data, address or data-port write
    always_ff @(posedge i_ref_clk)
    begin
        if (!i_rst_n)
            pin_out_q <= ppri_pkg::DATA_RST;
        else if (wr_data || wr_ead || wr_edt)
            pin_out_q <= hif.wdata;                        // [RULE6]
    end

    // Control register, bits 0 to 5 only
    always_ff @(posedge i_ref_clk)
    begin
        if (!i_rst_n)
            ctrl_q <= ppri_pkg::CTRL_RST;                  // [RULE17]
        else if (wr_ctl)
            ctrl_q <= hif.wdata[ppri_pkg::CTL_WIDTH-1:0];
    end

    // Timeout flag: a timeout in the clearing cycle still sets it
    always_ff @(posedge i_ref_clk)
    begin
        if (!i_rst_n)
            cycle_timeout_flag_q <= 1'b0;                  // [RULE10]
        else if (tmo_set)
            cycle_timeout_flag_q <= 1'b1;                  // [RULE9]
        else if (tmo_clr)
            cycle_timeout_flag_q <= 1'b0;                  // [RULE10]
    end

    // Enhanced cycle watchdog; a timed-out cycle is abandoned
    always_ff @(posedge i_ref_clk)
    begin
        if (!i_rst_n)
        begin
            ecyc_q      <= 1'b0;
            ecyc_wr_q   <= 1'b0;
            ecyc_addr_q <= 1'b0;
            tmr_q       <= '0;
        end
        else if (ecyc_start)
        begin
            ecyc_q      <= 1'b1;
            ecyc_wr_q   <= hif.wr_start;
            ecyc_addr_q <= hit_ead;
            tmr_q       <= '0;
        end
        else if (ecyc_done)
        begin
            ecyc_q <= 1'b0;
            tmr_q  <= '0;
        end
        else if (ecyc_q)
            tmr_q <= tmr_q + 1'b1;                         // [RULE9]
    end

    // Read data: status is frozen at the start, pin reads stay live
    always_ff @(posedge i_ref_clk)
    begin
        if (!i_rst_n)
        begin
            rd_q       <= 8'h00;
            rd_valid_q <= 1'b0;
            rd_live_q  <= 1'b0;
        end
        else if (hif.rd_start)
        begin
            rd_q       <= rd_mux;                          // [RULE8]
            rd_valid_q <= hit_any;                         // [RULE23]
            rd_live_q  <= hit_data & data_live;
        end
        else if (!hif.rd_active)
        begin
            rd_valid_q <= 1'b0;
            rd_live_q  <= 1'b0;
        end
        else if (rd_live_q || (ecyc_q && !ecyc_wr_q))
            rd_q <= pins_s;                                // [RULE7] [RULE3]
    end

    // Interrupt request on a rising acknowledge edge when gated on
    always_ff @(posedge i_ref_clk)
    begin
        if (!i_rst_n)
        begin
            ack_prev_q <= 1'b1;  // Idle level, so no false edge after reset
            irq_q      <= 1'b0;
        end
        else
        begin
            ack_prev_q <= ack_s;
            irq_q      <= ctrl_q[ppri_pkg::CTL_IRQ_GATE]
                          & ack_s & ~ack_prev_q;           // [RULE22]
        end
    end

    // Host side outputs
    assign o_host_data    = rd_q;
    assign o_host_data_oe = rd_valid_q & hif.rd_active;    // [RULE8]
    assign o_host_irq     = irq_q;

    // Pins float during an enhanced read so the peripheral can drive them
    wire logic enh_rd = ecyc_q & ~ecyc_wr_q;
    assign o_parallel_data_pins    = pin_out_q;            // [RULE6]
    assign o_parallel_data_pins_oe = ~dir_in & ~enh_rd;

    // Control pins
    assign o_inverted_strobe_pin = ~ctrl_q[ppri_pkg::CTL_STROBE];   // [RULE18]
    assign o_line_feed_pin       = ~ctrl_q[ppri_pkg::CTL_LINEFEED]; // [RULE19]
    assign o_printer_reinit_out  = ctrl_q[ppri_pkg::CTL_REINIT];    // [RULE20]
    assign o_device_choose_pin   = ~ctrl_q[ppri_pkg::CTL_CHOOSE];   // [RULE21]

    assign o_enh_cycle_active = ecyc_q;
    assign o_enh_cycle_write  = ecyc_q & ecyc_wr_q;
    assign o_enh_cycle_addr   = ecyc_q & ecyc_addr_q;

endmodule // ppri_port_regs

// >>> hw/ppri_pkg.sv
// Constants shared by the printer port register interface.
// Assumes a 25 MHz reference clock and a 3-bit register offset.
package ppri_pkg;

    // Register offsets from the port base
    localparam logic [2:0] OFS_DATA   = 3'h0;
    localparam logic [2:0] OFS_STATUS = 3'h1;
    localparam logic [2:0] OFS_CTRL   = 3'h2;
    localparam logic [2:0] OFS_EADDR  = 3'h3;
    localparam logic [2:0] OFS_EDATA0 = 3'h4;

    // Status field positions
    localparam int STS_TIMEOUT  = 0;
    localparam int STS_FAULT    = 3;
    localparam int STS_ONLINE   = 4;
    localparam int STS_NO_MEDIA = 5;
    localparam int STS_ACK      = 6;
    localparam int STS_NOT_OCC  = 7;

    // Control field positions
    localparam int CTL_STROBE   = 0;
    localparam int CTL_LINEFEED = 1;
    localparam int CTL_REINIT   = 2;
    localparam int CTL_CHOOSE   = 3;
    localparam int CTL_IRQ_GATE = 4;
    localparam int CTL_DIR      = 5;
    localparam int CTL_WIDTH    = 6;

    // Reset values
    localparam logic [7:0] DATA_RST            = 8'h00;
    localparam logic [7:0] EREG_RST            = 8'h00;
    localparam logic [CTL_WIDTH-1:0] CTRL_RST  = 6'h00;

    // Enhanced cycle watchdog
    localparam int CLK_MHZ        = 25;
    localparam int CYC_TIMEOUT_US = 10;
    localparam int CYC_TIMEOUT_CY = CYC_TIMEOUT_US * CLK_MHZ;
    localparam int TMR_W          = 9;

    // Port modes, from the configuration logic
    typedef enum logic [1:0] {
        PM_COMPAT   = 2'b00,
        PM_BIDIR    = 2'b01,
        PM_ENHANCED = 2'b10
    } ppri_mode_e;

endpackage

// >>> hw/ppri_host_if.sv
// Carries the synchronised, edge-decoded host access to the core.
// Assumes both ends run on the same reference clock.
`timescale 1ns/1ps
interface ppri_host_if;
    logic [2:0] offset;
    logic [7:0] wdata;
    logic       rd_start;
    logic       rd_active;
    logic       wr_start;
    logic       wr_end;

    modport front
    (
        output offset,
        output wdata,
        output rd_start,
        output rd_active,
        output wr_start,
        output wr_end
    );

    modport core
    (
        input  offset,
        input  wdata,
        input  rd_start,
        input  rd_active,
        input  wr_start,
        input  wr_end
    );
endinterface

// >>> hw/ppri_host_front.sv
// Host bus front end: synchronises strobes, select, offset and data.
// Assumes the host holds offset and data stable across each strobe.
`timescale 1ns/1ps
module ppri_host_front
(
    // Clock and reset
    input  wire logic       i_ref_clk,
    input  wire logic       i_rst_n,
    // Host pins
    input  wire logic       i_port_select,
    input  wire logic [2:0] i_host_offset,
    input  wire logic [7:0] i_host_data,
    input  wire logic       i_host_read_strobe_n,
    input  wire logic       i_host_write_strobe_n,
    // Decoded access
    ppri_host_if.front      hif
);

    logic [13:0] meta_q;
    logic [13:0] sync_q;
    logic        rd_act_q;
    logic        wr_act_q;
    logic [2:0]  ofs_q;
    logic [7:0]  wdata_q;

    wire logic       rd_n_s  = sync_q[13];
    wire logic       wr_n_s  = sync_q[12];
    wire logic       sel_s   = sync_q[11];
    wire logic [2:0] ofs_s   = sync_q[10:8];
    wire logic [7:0] data_s  = sync_q[7:0];
    wire logic       rd_act  = sel_s & ~rd_n_s;
    wire logic       wr_act  = sel_s & ~wr_n_s;
    wire logic       rd_rise = rd_act & ~rd_act_q;
    wire logic       wr_rise = wr_act & ~wr_act_q;

    // Two stages before anything looks at the pins
    always_ff @(posedge i_ref_clk)
    begin
        meta_q <= {i_host_read_strobe_n, i_host_write_strobe_n,
                   i_port_select, i_host_offset, i_host_data};
        sync_q <= meta_q;
    end

    always_ff @(posedge i_ref_clk)
    begin
        if (!i_rst_n)
        begin
            rd_act_q <= 1'b0;
            wr_act_q <= 1'b0;
            ofs_q    <= 3'h0;
            wdata_q  <= 8'h00;
        end
        else
        begin
            rd_act_q <= rd_act;
            wr_act_q <= wr_act;
            if (rd_rise || wr_rise)
                ofs_q <= ofs_s;
            // Track data while the strobe is low; the last value commits
            if (wr_act)
                wdata_q <= data_s;
        end
    end

    assign hif.offset    = (rd_rise || wr_rise) ? ofs_s : ofs_q;
    assign hif.wdata     = wr_act ? data_s : wdata_q;
    assign hif.rd_start  = rd_rise;
    assign hif.rd_active = rd_act;
    assign hif.wr_start  = wr_rise;
    // Trailing edge of the write strobe, or select dropping with it
    assign hif.wr_end    = wr_act_q & ~wr_act;

endmodule // ppri_host_front

// >>> tb/ppri_port_regs_chk.sv
// Checker: port-level timing properties of the printer port registers.
// Sees only the top module's ports; bound from the testbench.
`timescale 1ns/1ps
module ppri_port_regs_chk
(
    // Clock and reset
    input  wire logic       i_ref_clk,
    input  wire logic       i_rst_n,
    // Host side
    input  wire logic [1:0] i_port_mode,
    input  wire logic       i_port_select,
    input  wire logic [2:0] i_host_offset,
    input  wire logic       i_host_read_strobe_n,
    input  wire logic       i_host_write_strobe_n,
    input  wire logic [7:0] o_host_data,
    input  wire logic       o_host_data_oe,
    input  wire logic       o_host_irq,
    // Printer side
    input  wire logic       i_printer_acknowledge_input,
    input  wire logic [7:0] o_parallel_data_pins,
    input  wire logic       o_inverted_strobe_pin,
    input  wire logic       o_line_feed_pin,
    input  wire logic       o_printer_reinit_out,
    input  wire logic       o_device_choose_pin
);
    default clocking cb @(posedge i_ref_clk); endclocking
    default disable iff (!i_rst_n);

    chk_irq_pulse:
        assert property (o_host_irq |=> !o_host_irq)
        else $error("irq pulse longer than one cycle");
    chk_irq_cause:
        assert property (o_host_irq |->
            $past(i_printer_acknowledge_input, 3) &&
            !$past(i_printer_acknowledge_input, 4))
        else $error("irq without acknowledge rising edge");
    chk_read_start:
        assert property ($rose(o_host_data_oe) |->
            $past(!i_host_read_strobe_n && i_port_select, 2))
        else $error("read data driven without read strobe");
    chk_read_refused:
        assert property ($rose(o_host_data_oe) |->
            ($past(i_port_mode, 2) == ppri_pkg::PM_ENHANCED ||
             $past(i_host_offset, 2) < 3'h3))
        else $error("enhanced register answered outside enhanced mode");
    chk_status_hold:
        assert property (($past(o_host_data_oe) && o_host_data_oe &&
            i_host_offset == 3'h1) |-> $stable(o_host_data))
        else $error("status changed during read");
    chk_read_end:
        assert property ($rose(i_host_read_strobe_n) |->
            ##[1:4] !o_host_data_oe)
        else $error("read data still driven after strobe end");
    chk_status_zero:
        assert property ((o_host_data_oe && i_host_offset == 3'h1) |->
            o_host_data[2:1] == 2'b00)
        else $error("status bits 2:1 not zero");
    chk_ctrl_top:
        assert property ((o_host_data_oe && i_host_offset == 3'h2) |->
            o_host_data[7:6] == 2'b00)
        else $error("control bits 7:6 not zero");
    chk_data_write:
        assert property (($changed(o_parallel_data_pins) &&
            i_port_mode != ppri_pkg::PM_ENHANCED) |->
            $past(i_host_write_strobe_n, 1) &&
            !$past(i_host_write_strobe_n, 4) &&
            $past(i_host_offset, 4) == 3'h0)
        else $error("data pins changed without data write");
    chk_ctrl_write:
        assert property ($changed({o_inverted_strobe_pin, o_line_feed_pin,
            o_printer_reinit_out, o_device_choose_pin}) |->
            $past(i_host_write_strobe_n, 1) &&
            !$past(i_host_write_strobe_n, 4) &&
            $past(i_host_offset, 4) == 3'h2)
        else $error("control pins changed without control write");
endmodule // ppri_port_regs_chk

// >>> tb/ppri_printer_model.sv
// Printer model: status levels, wait handshake and reverse data drive.
// Assumes the bench sets its status levels between host accesses.
`timescale 1ns/1ps
module ppri_printer_model
(
    // Clock
    input  wire logic       i_ref_clk,
    // Device pins
    input  wire logic [7:0] i_dev_data,
    input  wire logic       i_dev_oe,
    input  wire logic       i_enh_active,
    // Cable levels
    output logic      [7:0] o_bus,
    output logic            o_fault_n,
    output logic            o_online,
    output logic            o_no_media,
    output logic            o_ack_n,
    output logic            o_busy,
    output logic            o_ready
);
    logic [7:0] drive_val;
    logic       slow;
    logic [1:0] rdy_cnt;

    // The printer drives the bus only while the device has let go
    assign o_bus   = i_dev_oe ? i_dev_data : drive_val;
    // Stalling keeps wait asserted so the device watchdog must expire
    assign o_ready = !slow && rdy_cnt == 2'h2;

    initial
    begin
        drive_val = 8'h00;
        slow      = 1'b0;
        rdy_cnt   = 2'h0;
        o_fault_n = 1'b1;
        o_online  = 1'b1;
        o_no_media = 1'b0;
        o_ack_n   = 1'b1;
        o_busy    = 1'b0;
    end

    always @(posedge i_ref_clk)
    begin
        if (!i_enh_active)
            rdy_cnt <= 2'h0;
        else if (rdy_cnt != 2'h2)
            rdy_cnt <= rdy_cnt + 2'h1;
    end

    task automatic pulse_ack();
        @(posedge i_ref_clk);
        o_ack_n <= 1'b0;
        repeat (12) @(posedge i_ref_clk);
        o_ack_n <= 1'b1;
        repeat (12) @(posedge i_ref_clk);
    endtask
endmodule // ppri_printer_model

// >>> tb/ppri_port_regs_test.sv
// Self-checking bench for the printer port registers.
// Drives host strobes per the hand-over timing; printer model on the cable.
`timescale 1ns/1ps
module ppri_port_regs_test;
    logic       clk, rst_n, sel, rd_n, wr_n, hoe, irq, poe, ro;
    logic       stb, lf, rin, cho, e_act, flt, onl, nom, ack, bsy, rdy;
    logic [1:0] mode;
    logic [2:0] ofs;
    logic [7:0] hdata, hq, pins, pout, rv, ctl_m, dat_m;
    int         error_cnt, samples_checked, v, n;

    ppri_port_regs uut
    (
        .i_ref_clk(clk), .i_rst_n(rst_n), .i_port_mode(mode),
        .i_port_select(sel), .i_host_offset(ofs), .i_host_data(hdata),
        .i_host_read_strobe_n(rd_n), .i_host_write_strobe_n(wr_n),
        .o_host_data(hq), .o_host_data_oe(hoe), .o_host_irq(irq),
        .i_parallel_data_pins(pins), .o_parallel_data_pins(pout),
        .o_parallel_data_pins_oe(poe), .i_fault_input_pin(flt),
        .i_online_input(onl), .i_no_media_input(nom),
        .i_printer_acknowledge_input(ack), .i_printer_busy(bsy),
        .i_periph_ready(rdy), .o_inverted_strobe_pin(stb),
        .o_line_feed_pin(lf), .o_printer_reinit_out(rin),
        .o_device_choose_pin(cho), .o_enh_cycle_active(e_act),
        .o_enh_cycle_write(), .o_enh_cycle_addr()
    );

    ppri_printer_model pm
    (
        .i_ref_clk(clk), .i_dev_data(pout), .i_dev_oe(poe),
        .i_enh_active(e_act), .o_bus(pins), .o_fault_n(flt),
        .o_online(onl), .o_no_media(nom), .o_ack_n(ack), .o_busy(bsy),
        .o_ready(rdy)
    );

    initial
    begin
        clk = 1'b0;
        forever #20 clk = ~clk;
    end

    task automatic cmp(input string what, input logic [7:0] exp,
                       input logic [7:0] got);
        samples_checked++;
        if (got !== exp)
        begin
            error_cnt++;
            $display("ERROR %s expected %h seen %h", what, exp, got);
        end
    endtask

    // One strobe held lo cycles; read data taken at the releasing edge
    task automatic acc(input logic wr, input logic [2:0] o,
                       input logic [7:0] d, input int lo);
        @(posedge clk);
        sel   <= 1'b1;
        ofs   <= o;
        hdata <= d;
        if (wr)
            wr_n <= 1'b0;
        else
            rd_n <= 1'b0;
        repeat (lo) @(posedge clk);
        rv = hq;
        ro = hoe;
        wr_n <= 1'b1;
        rd_n <= 1'b1;
        repeat (6) @(posedge clk);
        sel <= 1'b0;
    endtask

    task automatic ctl_pins();
        cmp("ctl_pins", {4'h0, ~ctl_m[3], ctl_m[2], ~ctl_m[1], ~ctl_m[0]},
            {4'h0, cho, rin, lf, stb});
    endtask

    task automatic finish_test();
        $display("checks %0d errors %0d", samples_checked, error_cnt);
        if (error_cnt == 0 && samples_checked > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask

    initial
    begin
        repeat (30000) @(posedge clk);
        error_cnt++;
        $display("ERROR watchdog expected done seen hang");
        finish_test();
    end

    initial
    begin
        {rst_n, sel, mode, ofs, hdata} = '0;
        {rd_n, wr_n} = 2'b11;
        error_cnt = 0;
        samples_checked = 0;
        ctl_m = 8'h00;
        v = $urandom(32'h6a15);
        repeat (10) @(posedge clk);
        rst_n <= 1'b1;
        acc(0, 3'h0, 8'h00, 6);
        cmp("data_rst", 8'h00, rv);
        acc(0, 3'h2, 8'h00, 6);
        cmp("ctrl_rst", 8'h00, rv);
        ctl_pins();
        repeat (4)
        begin
            v = $urandom;
            acc(1, 3'h2, v[7:0], 6);
            ctl_m = {2'b00, v[5:0]};
            acc(0, 3'h2, 8'h00, 6);
            cmp("ctrl", ctl_m, rv);
            ctl_pins();
            v = $urandom;
            acc(1, 3'h0, v[7:0], 6);
            dat_m = v[7:0];
            cmp("pins_out", dat_m, pout);
            acc(0, 3'h0, 8'h00, 6);
            cmp("data_rd", dat_m, rv);
        end
        mode <= ppri_pkg::PM_BIDIR;
        acc(1, 3'h2, 8'h20, 6);
        pm.drive_val <= 8'(~dat_m);
        acc(0, 3'h0, 8'h00, 6);
        cmp("data_live", ~dat_m, rv);
        mode <= ppri_pkg::PM_COMPAT;
        acc(1, 3'h2, 8'h00, 6);
        ctl_m = 8'h00;
        repeat (4)
        begin
            v = $urandom;
            @(posedge clk);
            {pm.o_fault_n, pm.o_online, pm.o_no_media, pm.o_ack_n,
             pm.o_busy} <= v[4:0];
            acc(0, 3'h1, 8'h00, 6);
            cmp("status", {~v[0], v[1], v[2], v[3], v[4], 3'b000}, rv);
        end
        pm.o_ack_n <= 1'b1;
        for (n = 3; n < 8; n++)
        begin
            v = $urandom;
            acc(1, n[2:0], v[7:0], 6);
            cmp("pins_keep", dat_m, pout);
            ctl_pins();
            acc(0, n[2:0], 8'h00, 6);
            cmp("oe_refused", 8'h00, {7'h00, ro});
        end
        for (v = 1; v >= 0; v--)
        begin
            acc(1, 3'h2, {3'h0, v[0], 4'h0}, 6);
            n = 0;
            fork
                pm.pulse_ack();
                repeat (30) @(posedge clk) if (irq === 1'b1) n++;
            join
            cmp("irq_cnt", 8'(v), 8'(n));
        end
        mode <= ppri_pkg::PM_ENHANCED;
        v = $urandom;
        acc(1, 3'h4, v[7:0], 6);
        cmp("enh_pins", v[7:0], pout);
        acc(0, 3'h4, 8'h00, 14);
        cmp("enh_rd_oe", 8'h01, {7'h00, ro});
        cmp("enh_rd", ~dat_m, rv);
        pm.slow <= 1'b1;
        for (n = 0; n < 2; n++)
        begin
            acc(1, 3'h5, v[7:0], 270);
            acc(0, 3'h1, 8'h00, 6);
            cmp("tmo_set", 8'h01, {7'h00, rv[0]});
        end
        acc(1, 3'h1, 8'h00, 6);
        acc(0, 3'h1, 8'h00, 6);
        cmp("tmo_keep", 8'h01, {7'h00, rv[0]});
        acc(1, 3'h1, 8'h01, 6);
        acc(0, 3'h1, 8'h00, 6);
        cmp("tmo_clear", 8'h00, {7'h00, rv[0]});
        acc(1, 3'h6, v[7:0], 270);
        // Reset in mid-run must clear the flag and the data latch
        rst_n <= 1'b0;
        repeat (3) @(posedge clk);
        rst_n <= 1'b1;
        pm.slow <= 1'b0;
        acc(0, 3'h1, 8'h00, 6);
        cmp("tmo_rst", 8'h00, {7'h00, rv[0]});
        cmp("pins_rst", 8'h00, pout);
        finish_test();
    end
endmodule // ppri_port_regs_test

bind ppri_port_regs ppri_port_regs_chk u_chk
(
    .i_ref_clk, .i_rst_n, .i_port_mode, .i_port_select, .i_host_offset,
    .i_host_read_strobe_n, .i_host_write_strobe_n, .o_host_data,
    .o_host_data_oe, .o_host_irq, .i_printer_acknowledge_input,
    .o_parallel_data_pins, .o_inverted_strobe_pin, .o_line_feed_pin,
    .o_printer_reinit_out, .o_device_choose_pin
);
